/* File: irap_pkg.sv */
// Purpose : shared constants and types of the indirect register access port
// Assumes : 125 MHz master clock, pins already synchronous to it
// Notes   : location codes, field positions and reset values live here
package irap_pkg;

    // ------------------------------------------------------------
    // interface locations (3-bit external address)
    // ------------------------------------------------------------
    localparam logic [2:0] LOC_DATA_BYTE_0    = 3'h0;  // data bits 7:0
    localparam logic [2:0] LOC_DATA_BYTE_1    = 3'h1;  // data bits 15:8
    localparam logic [2:0] LOC_DATA_BYTE_2    = 3'h2;  // data bits 23:16
    localparam logic [2:0] LOC_DATA_BYTE_3    = 3'h3;  // data bits 31:24
    localparam logic [2:0] LOC_DATA_NIBBLE_4  = 3'h4;  // data bits 35:32
    localparam logic [2:0] LOC_RESERVED       = 3'h5;  // reads zero
    localparam logic [2:0] LOC_LOW_ADDRESS    = 3'h6;  // address bits 7:0
    localparam logic [2:0] LOC_ADDRESS_MODE   = 3'h7;  // address 9:8, mode

    // ------------------------------------------------------------
    // field layout and widths
    // ------------------------------------------------------------
    localparam int IRAP_ADDR_W      = 10;  // internal address width
    localparam int IRAP_DATA_W      = 36;  // internal data width
    localparam int IRAP_NIB_W       = 4;   // used bits of location 100
    localparam int AMR_HI_ADDR_LSB  = 0;   // address bits 9:8 at 1:0
    localparam int AMR_RD_INC_BIT   = 6;   // increment after reads
    localparam int AMR_WR_INC_BIT   = 7;   // increment after writes

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE   = 8'h00;  // staged data bytes
    localparam logic [9:0]  RST_ADDR   = 10'h000;  // internal address
    localparam logic [1:0]  RST_INC    = 2'h0;   // auto increment off
    localparam logic [35:0] RST_WORD   = 36'h0_0000_0000;

    // ------------------------------------------------------------
    // handshake state machine, gray coded from IDLE to DONE along the fetch path
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,  // waiting for a port access
        ST_EXEC  = 3'b001,  // byte operation handed to the staging file
        ST_FETCH = 3'b011,  // internal read in flight
        ST_LATCH = 3'b010,  // staging file settled
        ST_DONE  = 3'b110   // handshake answered, wait for release
    } irap_state_t;

endpackage

/* File: irap_stage_if.sv */
// Purpose : carries byte operations and internal space traffic
// Assumes : one clock domain
// Notes   : the handshake engine drives strobes, the staging file answers
`timescale 1ns/100ps
interface irap_stage_if;
    logic        wr_stb;     // byte write, one cycle
    logic        rd_stb;     // byte read, one cycle
    logic [2:0]  loc;        // interface location
    logic [7:0]  wdata;      // byte written
    logic [7:0]  rdata;      // byte read back
    logic        int_req;    // internal transfer, one cycle
    logic        int_we;     // internal transfer direction
    logic [9:0]  int_addr;   // internal address
    logic [35:0] int_wdata;  // internal write word
    logic [35:0] int_rdata;  // internal read word, valid with int_req

    modport engine (output wr_stb, output rd_stb, output loc, output wdata,
                    output int_rdata, input rdata, input int_req,
                    input int_we, input int_addr, input int_wdata);
    modport stage  (input wr_stb, input rd_stb, input loc, input wdata,
                    input int_rdata, output rdata, output int_req,
                    output int_we, output int_addr, output int_wdata);
endinterface

/* File: irap_stage.sv */
// Purpose : staging file of data bytes, internal address and mode bits
// Assumes : internal space answers a read in the cycle of int_req
// Notes   : commits on a write of location 000, fetches on its read
`timescale 1ns/100ps
module irap_stage
    import irap_pkg::*;
(
    input  wire logic    clk_i,   // master clock
    input  wire logic    nrst_i,  // synchronous reset, active low
    irap_stage_if.stage  bus      // byte operations from the engine
);

    logic [7:0] byte_r [4];        // data bytes 0..3
    logic [3:0] nib4_r;            // data nibble 4
    logic [9:0] addr_r;            // internal address
    logic [1:0] inc_r;             // {write inc, read inc}
    logic       req_r;             // internal transfer pulse
    logic       we_r;              // direction of that transfer
    logic [35:0] word_r;           // word committed on a write

    // ------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------
    function automatic logic [7:0] rd_mux(input logic [2:0] l);
        case (l)
            LOC_DATA_BYTE_0:   rd_mux = byte_r[0];
            LOC_DATA_BYTE_1:   rd_mux = byte_r[1];
            LOC_DATA_BYTE_2:   rd_mux = byte_r[2];
            LOC_DATA_BYTE_3:   rd_mux = byte_r[3];
            LOC_DATA_NIBBLE_4: rd_mux = {4'h0, nib4_r};
            LOC_LOW_ADDRESS:   rd_mux = addr_r[7:0];
            LOC_ADDRESS_MODE:  rd_mux = {inc_r, 4'h0, addr_r[9:8]};
            default:           rd_mux = 8'h00;
        endcase
    endfunction

    assign bus.rdata     = rd_mux(bus.loc);
    assign bus.int_req   = req_r;
    assign bus.int_we    = we_r;
    assign bus.int_addr  = addr_r;
    assign bus.int_wdata = word_r;

    // ------------------------------------------------------------
    // data bytes: host writes, or load from an internal fetch
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_byte
            always_ff @(posedge clk_i)
            begin
                if (!nrst_i)
                    byte_r[g] <= RST_BYTE;
                else if (req_r && !we_r)
                    byte_r[g] <= bus.int_rdata[8*g +: 8];
                else if (bus.wr_stb && bus.loc == 3'(g))
                    byte_r[g] <= bus.wdata;
            end
        end
    endgenerate

    // nibble 4 keeps only its low four bits
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            nib4_r <= RST_BYTE[3:0];
        else if (req_r && !we_r)
            nib4_r <= bus.int_rdata[35:32];
        else if (bus.wr_stb && bus.loc == LOC_DATA_NIBBLE_4)
            nib4_r <= bus.wdata[3:0];
    end

    // ------------------------------------------------------------
    // internal transfer launch on location 000
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            req_r  <= 1'b0;
            we_r   <= 1'b0;
            word_r <= RST_WORD;
        end
        else
        begin
            req_r <= (bus.wr_stb || bus.rd_stb) && bus.loc == LOC_DATA_BYTE_0;
            if (bus.wr_stb && bus.loc == LOC_DATA_BYTE_0)
            begin
                we_r   <= 1'b1;
                word_r <= {nib4_r, byte_r[3], byte_r[2], byte_r[1], bus.wdata};
            end
            else if (bus.rd_stb && bus.loc == LOC_DATA_BYTE_0)
                we_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // address, mode and auto increment
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            addr_r <= RST_ADDR;
            inc_r  <= RST_INC;
        end
        else if (bus.wr_stb && bus.loc == LOC_LOW_ADDRESS)
            addr_r[7:0] <= bus.wdata;
        else if (bus.wr_stb && bus.loc == LOC_ADDRESS_MODE)
        begin
            addr_r[9:8] <= bus.wdata[AMR_HI_ADDR_LSB +: 2];
            inc_r <= {bus.wdata[AMR_WR_INC_BIT], bus.wdata[AMR_RD_INC_BIT]};
        end
        else if (req_r && (we_r ? inc_r[1] : inc_r[0]))
            addr_r <= addr_r + 10'h001;
    end

endmodule

/* File: irap_port.sv */
// Purpose : handshake engine of the indirect register access port
// Assumes : pins synchronous to clk_i; internal space answers in one cycle
// Notes   : serial control requests share the staging file and win
//
// Function
// - eight byte locations, 101 reserved
// - locations 000-100 map data bits 35:0
// - 10-bit address in locations 110 and 111
// - write of 000 commits staged word
// - read of 000 fetches whole word
// - mode bits 7:6 select auto increment
// - mode pin selects strobe or acknowledge style
// - port is synchronous to master clock
// - serial port reaches same locations
// - style 0 ready low until cycle done
// - ready high at N+3 for 000 reads
// - style 1 acknowledge low until strobe released
// - serial access wins, microport waits
`timescale 1ns/100ps
module irap_port
    import irap_pkg::*;
(
    input  wire logic        clk_i,         // master clock, 125 MHz
    input  wire logic        nrst_i,        // synchronous reset, active low
    input  wire logic        mode_i,        // handshake style select
    input  wire logic        cs_n_i,        // chip select, active low
    input  wire logic        rd_n_i,        // read strobe / data_strobe_n
    input  wire logic        wr_n_i,        // write strobe / read-write select
    input  wire logic [2:0]  addr_i,        // interface location
    input  wire logic [7:0]  data_i,        // data pins, input side
    output logic      [7:0]  data_o,        // data pins, output side
    output logic             data_oe_o,     // data pins driven
    output logic             rdy_o,         // style 0 ready
    output logic             transfer_ack_n_o, // style 1 acknowledge
    input  wire logic        ser_req_i,     // serial byte access, pulse
    input  wire logic        ser_we_i,      // serial access is a write
    input  wire logic [2:0]  ser_loc_i,     // serial location
    input  wire logic [7:0]  ser_wdata_i,   // serial write byte
    output logic      [7:0]  ser_rdata_o,   // serial read byte
    output logic             ser_done_o,    // serial access done, pulse
    output logic             int_req_o,     // internal transfer, pulse
    output logic             int_we_o,      // internal transfer is write
    output logic      [9:0]  int_addr_o,    // internal address
    output logic      [35:0] int_wdata_o,   // internal write word
    input  wire logic [35:0] int_rdata_i    // internal read word
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    irap_stage_if stg ();             // link to the staging file

    irap_state_t state_r;             // handshake state
    irap_state_t state_nxt;           // next handshake state
    logic        src_ser_r;           // current access is serial
    logic        is_wr_r;             // current access is a write
    logic [2:0]  loc_r;               // current location
    logic [7:0]  wbyte_r;             // current write byte
    logic        ser_pend_r;          // serial request waiting
    logic        ser_we_r;            // waiting serial direction
    logic [2:0]  ser_loc_r;           // waiting serial location
    logic [7:0]  ser_wd_r;            // waiting serial byte
    logic [7:0]  data_r;              // read byte to data pins
    logic        data_oe_r;           // data pins driven
    logic        rdy_r;               // ready pin
    logic        ack_n_r;             // acknowledge pin
    logic [7:0]  ser_rd_r;            // serial read byte
    logic        ser_done_r;          // serial done pulse
    logic        up_act;              // microport access requested
    logic        up_wr;               // microport access is a write
    logic        fetch;               // access is a read of 000
    logic [1:0]  up_dec;              // decoded {request, write}

    // ------------------------------------------------------------
    // pin decode of both handshake styles
    // ------------------------------------------------------------
    // style 0: separate strobes; style 1: strobe plus direction
    function automatic logic [1:0] up_decode(input logic m, input logic cs_n,
                                             input logic rd_n, input logic wr_n);
        if (cs_n)
            up_decode = 2'b00;
        else if (m)
            up_decode = {!rd_n, !wr_n};
        else
            up_decode = {!rd_n || !wr_n, !wr_n};
    endfunction

    // decode once, then split into request and direction
    assign up_dec = up_decode(mode_i, cs_n_i, rd_n_i, wr_n_i);

    // pins are sampled straight on clk_i, no resync stage; a host much
    // faster than clk_i must bring its strobes onto clk_i first
    assign up_act = up_dec[1];
    assign up_wr  = up_dec[0];

    // a read of data location 000 takes the extra fetch cycle
    assign fetch = !is_wr_r && loc_r == LOC_DATA_BYTE_0;

    // ------------------------------------------------------------
    // staging file hookup
    // ------------------------------------------------------------
    assign stg.wr_stb    = state_r == ST_EXEC && is_wr_r;
    assign stg.rd_stb    = state_r == ST_EXEC && !is_wr_r;
    assign stg.loc       = loc_r;
    assign stg.wdata     = wbyte_r;
    assign stg.int_rdata = int_rdata_i;

    irap_stage u_stage (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .bus    (stg.stage)
    );

    // internal space signals come from staging flip-flops
    assign int_req_o   = stg.int_req;
    assign int_we_o    = stg.int_we;
    assign int_addr_o  = stg.int_addr;
    assign int_wdata_o = stg.int_wdata;

    // ------------------------------------------------------------
    // serial request capture
    // ------------------------------------------------------------
    // a serial byte access is held until the engine is free
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            ser_pend_r <= 1'b0;
            ser_we_r   <= 1'b0;
            ser_loc_r  <= 3'h0;
            ser_wd_r   <= RST_BYTE;
        end
        else if (ser_req_i)
        begin
            // a new request wins over the take in the same cycle
            ser_pend_r <= 1'b1;
            ser_we_r   <= ser_we_i;
            ser_loc_r  <= ser_loc_i;
            ser_wd_r   <= ser_wdata_i;
        end
        else if (state_r == ST_IDLE)
            ser_pend_r <= 1'b0;                                  // taken
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
            begin
                if (ser_pend_r || up_act)
                    state_nxt = ST_EXEC;
            end
            ST_EXEC:
            begin
                if (fetch)
                    state_nxt = ST_FETCH;
                else
                    state_nxt = ST_LATCH;
            end
            ST_FETCH:
                state_nxt = ST_LATCH;
            ST_LATCH:
                state_nxt = ST_DONE;
            ST_DONE:
            begin
                // serial leaves at once, microport waits for release
                if (src_ser_r || !up_act)
                    state_nxt = ST_IDLE;
            end
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // ------------------------------------------------------------
    // access capture and arbitration
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            src_ser_r <= 1'b0;
            is_wr_r   <= 1'b0;
            loc_r     <= 3'h0;
            wbyte_r   <= RST_BYTE;
        end
        else if (state_r == ST_IDLE && ser_pend_r)
        begin
            // serial access is served first
            src_ser_r <= 1'b1;
            is_wr_r   <= ser_we_r;
            loc_r     <= ser_loc_r;
            wbyte_r   <= ser_wd_r;
        end
        else if (state_r == ST_IDLE && up_act)
        begin
            src_ser_r <= 1'b0;
            is_wr_r   <= up_wr;
            loc_r     <= addr_i;
            wbyte_r   <= data_i;
        end
    end

    // ------------------------------------------------------------
    // style 0 ready
    // ------------------------------------------------------------
    // low from the access edge N, high again at N+2, or N+3 for fetches
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            rdy_r <= 1'b1;
        else if (state_r == ST_IDLE && (ser_pend_r || up_act))
            rdy_r <= 1'b0;
        else if (state_r == ST_LATCH)
            rdy_r <= 1'b1;
    end

    // ------------------------------------------------------------
    // style 1 acknowledge
    // ------------------------------------------------------------
    // low for a microport access once answered, high on release
    // a serial access never moves it, the microport simply waits longer
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            ack_n_r <= 1'b1;
        else if (state_r == ST_LATCH && !src_ser_r && mode_i)
            ack_n_r <= 1'b0;
        else if (state_r == ST_DONE && state_nxt == ST_IDLE)
            ack_n_r <= 1'b1;
    end

    // ------------------------------------------------------------
    // read data to the microport pins
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            data_r    <= RST_BYTE;
            data_oe_r <= 1'b0;
        end
        else if (state_r == ST_LATCH && !src_ser_r && !is_wr_r)
        begin
            data_r    <= stg.rdata;
            data_oe_r <= 1'b1;
        end
        else if (state_r == ST_DONE && state_nxt == ST_IDLE)
            data_oe_r <= 1'b0;                                   // bus released
    end

    // ------------------------------------------------------------
    // serial answer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            ser_rd_r   <= RST_BYTE;
            ser_done_r <= 1'b0;
        end
        else
        begin
            ser_done_r <= state_r == ST_LATCH && src_ser_r;
            if (state_r == ST_LATCH && src_ser_r && !is_wr_r)
                ser_rd_r <= stg.rdata;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // style 0 keeps the acknowledge idle, ready moves in both styles
    assign data_o           = data_r;
    assign data_oe_o        = data_oe_r;
    assign rdy_o            = rdy_r;
    assign transfer_ack_n_o = ack_n_r;
    assign ser_rdata_o      = ser_rd_r;
    assign ser_done_o       = ser_done_r;

endmodule

/* File: irap_mem_model.sv */
// Purpose: internal register space seen behind the access port
// Assumes: one clock, reads answered in the request cycle
// Notes: shows an inverted word outside requests
`timescale 1ns/100ps
module irap_mem_model (
    input  wire logic        clk_i,
    input  wire logic        int_req_i,
    input  wire logic        int_we_i,
    input  wire logic [9:0]  int_addr_i,
    input  wire logic [35:0] int_wdata_i,
    output logic      [35:0] int_rdata_o
);
    logic [35:0] mem [0:1023];  // internal words
    // stale data must not look valid, so it is inverted
    assign int_rdata_o = int_req_i ? mem[int_addr_i] : ~mem[int_addr_i];
    // commit on a write transfer
    always_ff @(posedge clk_i)
    begin
        if (int_req_i && int_we_i)
            mem[int_addr_i] <= int_wdata_i;
    end
endmodule

/* File: irap_port_assertions.sv */
// Purpose: port checks of the access port
// Assumes: sees only the top module ports
// Notes: handshake figures of the hand-over
`timescale 1ns/100ps
module irap_port_chk (
    input wire logic       clk_i, nrst_i, mode_i, cs_n_i, rd_n_i, wr_n_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] data_o,
    input wire logic       data_oe_o, rdy_o, transfer_ack_n_o,
    input wire logic       int_req_o, int_we_o, ser_done_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    wire logic s0_loc0 = !mode_i && addr_i == 3'h0;  // style 0, byte 000
    chk_ack_style0: assert property (!mode_i |-> transfer_ack_n_o)
        else $error("ack low in strobe style");
    chk_rdy_fetch: assert property ($fell(rdy_o) && s0_loc0 && wr_n_i
        |=> !rdy_o [*2] ##1 rdy_o) else $error("ready late or early on fetch");
    chk_rdy_short: assert property ($fell(rdy_o) && !mode_i
        && (addr_i != 3'h0 || !wr_n_i) |=> !rdy_o ##1 rdy_o) else $error("ready span");
    chk_read_fetch: assert property ($fell(rdy_o) && s0_loc0 && wr_n_i
        |=> int_req_o && !int_we_o) else $error("no fetch on byte 000 read");
    chk_write_commit: assert property ($fell(rdy_o) && s0_loc0 && !wr_n_i
        |=> int_req_o && int_we_o) else $error("no commit on byte 000 write");
    chk_no_transfer: assert property ($fell(rdy_o) && !mode_i && addr_i != 3'h0
        |-> ##1 !int_req_o ##1 !int_req_o) else $error("stray transfer");
    chk_rsvd_zero: assert property ($rose(rdy_o) && !mode_i && data_oe_o
        && addr_i == 3'h5 |-> data_o == 8'h00) else $error("reserved not zero");
    chk_nibble_zero: assert property ($rose(rdy_o) && !mode_i && data_oe_o
        && addr_i == 3'h4 |-> data_o[7:4] == 4'h0) else $error("nibble top set");
    chk_ack_held: assert property (mode_i && !transfer_ack_n_o && !rd_n_i
        && !cs_n_i |=> !transfer_ack_n_o) else $error("ack dropped early");
    chk_ack_release: assert property (mode_i && !transfer_ack_n_o
        && (rd_n_i || cs_n_i) |-> ##[1:2] transfer_ack_n_o) else $error("ack stuck");
    chk_done_pulse: assert property (ser_done_o |=> !ser_done_o)
        else $error("serial done too long");
endmodule
bind irap_port irap_port_chk u_chk (.clk_i, .nrst_i, .mode_i, .cs_n_i, .rd_n_i,
    .wr_n_i, .addr_i, .data_o, .data_oe_o, .rdy_o, .transfer_ack_n_o,
    .int_req_o, .int_we_o, .ser_done_o);

/* File: tb_indirect_register_access_port.sv */
// Purpose: self-checking bench of the access port
// Assumes: inputs driven at the falling edge
// Notes: internal space is a behavioural memory
`timescale 1ns/100ps
module tb_indirect_register_access_port;
    logic clk_i, nrst_i, mode_i, cs_n_i, rd_n_i, wr_n_i, ser_req_i, ser_we_i;
    logic [2:0] addr_i, ser_loc_i;
    logic [7:0] data_i, ser_wdata_i, data_o, ser_rdata_o, rd, srd;
    logic data_oe_o, rdy_o, transfer_ack_n_o, ser_done_o, int_req_o, int_we_o;
    logic [9:0] int_addr_o;
    logic [35:0] int_wdata_o, int_rdata_i;
    int mismatches, cmp_count;
    irap_port DUT (.clk_i, .nrst_i, .mode_i, .cs_n_i, .rd_n_i, .wr_n_i, .addr_i,
        .data_i, .data_o, .data_oe_o, .rdy_o, .transfer_ack_n_o, .ser_req_i,
        .ser_we_i, .ser_loc_i, .ser_wdata_i, .ser_rdata_o, .ser_done_o,
        .int_req_o, .int_we_o, .int_addr_o, .int_wdata_o, .int_rdata_i);
    irap_mem_model u_mem (.clk_i, .int_req_i(int_req_o), .int_we_i(int_we_o),
        .int_addr_i(int_addr_o), .int_wdata_i(int_wdata_o), .int_rdata_o(int_rdata_i));
    initial
    begin
        clk_i = 0;
        forever #4 clk_i = ~clk_i;
    end
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one microport access in the current style, answer taken at the edge
    task automatic acc(input logic we, input logic [2:0] loc, input logic [7:0] wd);
        int n;
        logic low;
        low = 0;
        @(negedge clk_i);
        cs_n_i = 0;
        addr_i = loc;
        data_i = wd;
        rd_n_i = mode_i ? 1'b0 : we;
        wr_n_i = !we;
        for (n = 0; n < 40; n++)
        begin
            @(posedge clk_i);
            if (mode_i ? !transfer_ack_n_o : (low && rdy_o))
                break;
            low = low | !rdy_o;
        end
        if (n == 40)
        begin
            mismatches++;
            give_verdict();
        end
        rd = data_o;
        chk("drive", 36'(!we), 36'(data_oe_o));
        @(negedge clk_i);
        cs_n_i = 1;
        rd_n_i = 1;
        wr_n_i = 1;
        repeat (3) @(negedge clk_i);
    endtask
    // one serial byte request, called at a falling edge
    task automatic ser(input logic we, input logic [2:0] loc, input logic [7:0] wd);
        int n;
        ser_req_i = 1;
        ser_we_i = we;
        ser_loc_i = loc;
        ser_wdata_i = wd;
        @(negedge clk_i);
        ser_req_i = 0;
        for (n = 0; n < 40 && !ser_done_o; n++)
            @(posedge clk_i);
        if (n == 40)
        begin
            mismatches++;
            give_verdict();
        end
        srd = ser_rdata_o;
        @(negedge clk_i);
    endtask
    initial
    begin
        {nrst_i, mode_i, ser_req_i, ser_we_i, ser_loc_i, ser_wdata_i} = '0;
        {cs_n_i, rd_n_i, wr_n_i, addr_i, data_i} = {3'h7, 11'h0};
        mismatches = 0;
        cmp_count = 0;
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
        nrst_i = 1;
        chk("ready", 1, rdy_o);
        chk("address", 0, int_addr_o);
        $display("reset test done");
        acc(1, 3'h7, 8'hfd);
        acc(1, 3'h6, 8'h23);
        acc(0, 3'h7, 0);
        chk("mode byte", 8'hc1, rd);
        for (int i = 4; i > 0; i--)
            acc(1, 3'(i), 8'hf0 | 8'(i));
        acc(1, 3'h0, 8'h5a);
        chk("word", 36'h4_f3f2_f15a, u_mem.mem[10'h123]);
        chk("inc write", 10'h124, int_addr_o);
        $display("write test done");
        acc(1, 3'h6, 8'h23);
        acc(0, 3'h0, 0);
        chk("byte 000", 8'h5a, rd);
        acc(0, 3'h4, 0);
        chk("nibble", 8'h04, rd);
        chk("masked", 8'h04, rd & 8'h0f);
        acc(0, 3'h1, 0);
        chk("byte 001", 8'hf1, rd);
        acc(0, 3'h5, 0);
        chk("reserved", 8'h00, rd);
        chk("inc read", 10'h124, int_addr_o);
        $display("read test done");
        for (int m = 0; m < 4; m++)
        begin
            acc(1, 3'h7, 8'(m << 6));
            acc(1, 3'h6, 8'h10);
            acc(1, 3'h0, 8'h00);
            chk("after write", 10'h10 + 10'(m[1]), int_addr_o);
            acc(0, 3'h0, 0);
            chk("after read", 10'h10 + 10'(m[1]) + 10'(m[0]), int_addr_o);
        end
        $display("increment test done");
        @(negedge clk_i);
        mode_i = 1;
        ser(1, 3'h6, 8'h55);
        fork
            ser(0, 3'h6, 0);
            acc(1, 3'h6, 8'h77);
        join
        chk("serial read", 8'h55, srd);
        acc(0, 3'h6, 0);
        chk("style 1 read", 8'h77, rd);
        acc(1, 3'h6, 8'h3c);
        ser(0, 3'h6, 0);
        chk("serial sees", 8'h3c, srd);
        $display("contention test done");
        give_verdict();
    end
endmodule
